// *** sgbm_defines.svh ***
// named offsets, mode fields, command codes and constants for the sgram burst block
`ifndef SGBM_DEFINES_SVH
`define SGBM_DEFINES_SVH
`define SGBM_OFF_MODE 4'h0
`define SGBM_OFF_STATUS 4'h4
`define SGBM_OFF_PMASK 4'h8
`define SGBM_OFF_COLOUR 4'hC
`define SGBM_MODE_RST 11'h020
`define SGBM_BL_LSB 0
`define SGBM_BL_MSB 2
`define SGBM_BT_BIT 3
`define SGBM_CL_LSB 4
`define SGBM_CL_MSB 6
`define SGBM_SWB_BIT 9
`define SGBM_SM_MASK_BIT 5
`define SGBM_SM_COLOUR_BIT 6
`define SGBM_ALLBANK_BIT 10
`define SGBM_BL1 3'h0
`define SGBM_BL2 3'h1
`define SGBM_BL4 3'h2
`define SGBM_BL8 3'h3
`define SGBM_BLFP 3'h7
`define SGBM_CL3 3'h3
`define SGBM_CMD_MODE 3'h0
`define SGBM_CMD_PRE 3'h2
`define SGBM_CMD_ACT 3'h3
`define SGBM_CMD_WRITE 3'h4
`define SGBM_CMD_READ 3'h5
`define SGBM_CMD_STOP 3'h6
`define SGBM_ZERO32 32'h0000_0000
`define SGBM_ONES32 32'hFFFF_FFFF
`define SGBM_BLK_ALL 8'hFF
`endif

// *** sgbm_pkg.sv ***
// shared types of the sgram burst block
package sgbm_pkg;
    typedef enum logic [2:0] {
        SGBM_IDLE = 3'h1,
        SGBM_RD = 3'h2,
        SGBM_WR = 3'h4
    } sgbm_state_t;
    typedef logic [7:0] sgbm_col_t;
endpackage

// *** sgbm_burst_if.sv ***
// carrier between the burst controller and the column sequencer
`timescale 1ns/10ps
interface sgbm_burst_if;
    sgbm_pkg::sgbm_col_t startCol;
    logic [2:0] lenCode;
    logic interleave;
    sgbm_pkg::sgbm_col_t beatIdx;
    sgbm_pkg::sgbm_col_t col;
    logic lastBeat;
    modport ctl(output startCol, lenCode, interleave, beatIdx, input col, lastBeat);
    modport seq(input startCol, lenCode, interleave, beatIdx, output col, lastBeat);
endinterface

// *** sgbm_burst_seq.sv ***
// column sequencer: burst order and wrap for one beat of a burst
`timescale 1ns/10ps
`include "sgbm_defines.svh"
module sgbm_burst_seq (
    sgbm_burst_if.seq bus
);
    import sgbm_pkg::*;

    // low bits that move within the burst; reserved codes behave as length one
    function automatic sgbm_col_t lenMask(input logic [2:0] code);
        case (code)
            `SGBM_BL2: lenMask = 8'h01;
            `SGBM_BL4: lenMask = 8'h03;
            `SGBM_BL8: lenMask = 8'h07;
            `SGBM_BLFP: lenMask = 8'hFF;
            default: lenMask = 8'h00;
        endcase
    endfunction

    wire sgbm_col_t wrapMask = lenMask(bus.lenCode);
    wire sgbm_col_t seqOff = 8'(bus.startCol + bus.beatIdx);
    wire sgbm_col_t intOff = bus.startCol ^ bus.beatIdx;
    wire useInter = bus.interleave && (bus.lenCode == `SGBM_BL4 || bus.lenCode == `SGBM_BL8);
    wire sgbm_col_t inBurst = useInter ? intOff : seqOff;

    assign bus.col = (bus.startCol & ~wrapMask) | (inBurst & wrapMask);
    // full page has no natural end
    assign bus.lastBeat = (bus.lenCode != `SGBM_BLFP) && (bus.beatIdx == wrapMask);
endmodule

// *** sgbm_top.sv ***
// sgram burst sequencing, write masking and block write with an avalon register port
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "sgbm_defines.svh"
// Functional notes
// - burst type 0 counts sequentially, wrapping
// - type 1 interleaves for four, eight
// - interleaved eight: 000 rises, 111 falls
// - sequential full page steps, wraps at 256
// - a column command is accepted every clock
// - mode bits 2..0 select burst length
// - single write option makes writes one column
// - block write fills eight aligned columns
// - stop: no write, reads drain latency minus one
// - same bank precharge ends the burst
// - new column command ends burst, starts new
// - plane mask zero keeps stored bit
// - activate with special input arms plane mask
// - byte mask high keeps stored byte
// - block write pins gate each pixel
// - load colour captures all 32 pins
// - special input high on write: block write
module sgbm_top (
    input logic clk,
    input logic rstn,
    input logic clkEn,
    input logic chipSelN,
    input logic rowStrobeN,
    input logic colStrobeN,
    input logic writeEnN,
    input logic bankSel,
    input logic [10:0] addr,
    input logic specialFunctionInput,
    input logic [31:0] dqIn,
    input logic [3:0] dqm,
    output logic [31:0] dqOut,
    output logic dqOe,
    input logic [3:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [31:0] avs_writedata,
    input logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import sgbm_pkg::*;

    logic [1:0] rstSyncQ;
    logic [10:0] modeQ;
    logic [31:0] planeMaskQ;
    logic [31:0] colourQ;
    logic [1:0] wpbEnQ;
    sgbm_state_t stateQ;
    logic bankQ;
    sgbm_col_t startColQ;
    sgbm_col_t beatQ;
    sgbm_col_t accColQ;
    logic [31:0] rdPipeQ [2];
    logic [1:0] rdValidQ;
    logic [31:0] dqOutQ;
    logic dqOeQ;
    logic [31:0] avsRdQ;
    logic waitQ;
    logic [31:0] memQ [512];

    sgbm_burst_if burst ();

    sgbm_burst_seq u_seq (
        .bus(burst)
    );

    // reset released through two flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstSyncQ <= 2'h0;
        end else begin
            rstSyncQ <= {rstSyncQ[0], 1'h1};
        end
    end
    wire rstnInt = rstSyncQ[1];

    // command decode
    wire [2:0] cmdCode = {rowStrobeN, colStrobeN, writeEnN};
    wire cmdOn = !chipSelN;
    wire cmdAct = cmdOn && cmdCode == `SGBM_CMD_ACT;
    wire cmdRead = cmdOn && cmdCode == `SGBM_CMD_READ;
    wire cmdWrite = cmdOn && cmdCode == `SGBM_CMD_WRITE;
    wire cmdPre = cmdOn && cmdCode == `SGBM_CMD_PRE;
    wire cmdStop = cmdOn && cmdCode == `SGBM_CMD_STOP;
    wire cmdMode = cmdOn && cmdCode == `SGBM_CMD_MODE;
    wire colCmd = cmdRead || cmdWrite;
    wire blockCmd = cmdWrite && specialFunctionInput;
    wire normWrCmd = cmdWrite && !specialFunctionInput;

    wire [2:0] blCode = modeQ[`SGBM_BL_MSB:`SGBM_BL_LSB];
    wire [2:0] clCode = modeQ[`SGBM_CL_MSB:`SGBM_CL_LSB];
    wire busy = stateQ != SGBM_IDLE;
    wire resvLen = blCode[2] && blCode != `SGBM_BLFP;

    // interruptions of a running burst
    wire preHits = cmdPre && (addr[`SGBM_ALLBANK_BIT] || bankSel == bankQ);
    wire stopNow = cmdStop || preHits;

    // length of the access that owns this cycle
    wire isWrNow = colCmd ? cmdWrite : stateQ == SGBM_WR;
    wire oneCol = blockCmd || (isWrNow && modeQ[`SGBM_SWB_BIT]);

    assign burst.startCol = colCmd ? addr[7:0] : startColQ;
    assign burst.beatIdx = colCmd ? 8'h00 : beatQ;
    assign burst.lenCode = oneCol ? `SGBM_BL1 : blCode;
    assign burst.interleave = modeQ[`SGBM_BT_BIT];

    // a new column command always wins over the burst in flight
    wire accessNow = colCmd || (busy && !stopNow);
    wire rdAcc = accessNow && (colCmd ? cmdRead : stateQ == SGBM_RD);
    wire normWrAcc = accessNow && (colCmd ? normWrCmd : stateQ == SGBM_WR);
    wire blkAcc = blockCmd;
    wire accBank = colCmd ? bankSel : bankQ;
    wire sgbm_col_t accCol = burst.col;
    wire [31:0] planeSel = wpbEnQ[accBank] ? planeMaskQ : `SGBM_ONES32;

    // eight column write lanes, one per column of an aligned block
    logic [31:0] colNew [8];
    logic [8:0] colIdx [8];
    logic [7:0] colHit;
    genvar k, b;
    generate
        for (k = 0; k < 8; k++) begin : g_col
            assign colIdx[k] = {accBank, accCol[7:3], 3'(k)};
            assign colHit[k] = blkAcc || (normWrAcc && accCol[2:0] == 3'(k));
            for (b = 0; b < 4; b++) begin : g_byte
                wire [7:0] oldByte = memQ[colIdx[k]][b*8 +: 8];
                wire [7:0] src = blkAcc ? colourQ[b*8 +: 8] : dqIn[b*8 +: 8];
                wire [7:0] pm = planeSel[b*8 +: 8];
                // pixel enable in block write, byte mask over everything
                wire keep = dqm[b] || (blkAcc && !dqIn[b*8 + k]);
                assign colNew[k][b*8 +: 8] = keep ? oldByte :
                    (oldByte & ~pm) | (src & pm);
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (clkEn && rstnInt) begin
            for (int i = 0; i < 8; i++) begin
                if (colHit[i]) begin
                    memQ[colIdx[i]] <= colNew[i];
                end
            end
        end
    end

    // burst state
    always_ff @(posedge clk or negedge rstnInt) begin
        if (!rstnInt) begin
            stateQ <= SGBM_IDLE;
            bankQ <= 1'h0;
            startColQ <= 8'h00;
            beatQ <= 8'h00;
            accColQ <= 8'h00;
        end else if (clkEn) begin
            if (accessNow) begin
                accColQ <= accCol;
            end
            if (colCmd) begin
                stateQ <= burst.lastBeat ? SGBM_IDLE : (cmdRead ? SGBM_RD : SGBM_WR);
                bankQ <= bankSel;
                startColQ <= addr[7:0];
                beatQ <= 8'h01;
            end else if (busy) begin
                if (stopNow || burst.lastBeat) begin
                    stateQ <= SGBM_IDLE;
                end
                beatQ <= 8'(beatQ + 8'h01);
            end
        end
    end

    // mode, plane mask, colour and per bank plane mask enables
    wire avsWrTake = avs_write && !waitQ;
    wire avsModeWr = avsWrTake && avs_address == `SGBM_OFF_MODE;
    wire [10:0] avsModeVal = {avs_byteenable[1] ? avs_writedata[10:8] : modeQ[10:8],
                              avs_byteenable[0] ? avs_writedata[7:0] : modeQ[7:0]};
    always_ff @(posedge clk or negedge rstnInt) begin
        if (!rstnInt) begin
            modeQ <= `SGBM_MODE_RST;
            planeMaskQ <= `SGBM_ONES32;
            colourQ <= `SGBM_ZERO32;
            wpbEnQ <= 2'h0;
        end else if (clkEn) begin
            if (cmdMode && !specialFunctionInput) begin
                modeQ <= addr;
            end else if (avsModeWr) begin
                modeQ <= avsModeVal;
            end
            if (cmdMode && specialFunctionInput && addr[`SGBM_SM_MASK_BIT]) begin
                planeMaskQ <= dqIn;
            end
            if (cmdMode && specialFunctionInput && addr[`SGBM_SM_COLOUR_BIT]) begin
                colourQ <= dqIn;
            end
            if (cmdAct) begin
                wpbEnQ[bankSel] <= specialFunctionInput;
            end
        end
    end

    // read data pipe: latency two uses stage 0, latency three stage 1
    wire [31:0] rdWord = memQ[{accBank, accCol}];
    wire cl3 = clCode == `SGBM_CL3;
    always_ff @(posedge clk or negedge rstnInt) begin
        if (!rstnInt) begin
            rdPipeQ[0] <= `SGBM_ZERO32;
            rdPipeQ[1] <= `SGBM_ZERO32;
            rdValidQ <= 2'h0;
            dqOutQ <= `SGBM_ZERO32;
            dqOeQ <= 1'h0;
        end else if (clkEn) begin
            rdPipeQ[0] <= rdWord;
            rdPipeQ[1] <= rdPipeQ[0];
            rdValidQ <= {rdValidQ[0], rdAcc};
            dqOutQ <= cl3 ? rdPipeQ[1] : rdPipeQ[0];
            dqOeQ <= cl3 ? rdValidQ[1] : rdValidQ[0];
        end
    end
    assign dqOut = dqOutQ;
    assign dqOe = dqOeQ;

    // register slave: one wait cycle, then the answer
    wire [31:0] statusWord = {13'h0000, wpbEnQ, resvLen, accColQ, 5'h00, bankQ,
                              stateQ == SGBM_WR, busy};
    wire [31:0] avsMux = (avs_address == `SGBM_OFF_MODE) ? {21'h00_0000, modeQ} :
                         (avs_address == `SGBM_OFF_STATUS) ? statusWord :
                         (avs_address == `SGBM_OFF_PMASK) ? planeMaskQ :
                         (avs_address == `SGBM_OFF_COLOUR) ? colourQ : `SGBM_ZERO32;
    always_ff @(posedge clk or negedge rstnInt) begin
        if (!rstnInt) begin
            waitQ <= 1'h1;
            avsRdQ <= `SGBM_ZERO32;
        end else if (clkEn) begin
            waitQ <= !((avs_read || avs_write) && waitQ);
            if (avs_read && waitQ) begin
                avsRdQ <= avsMux;
            end
        end
    end
    assign avs_readdata = avsRdQ;
    assign avs_waitrequest = waitQ;

    AST_SEQ_EIGHT_STEP: assert property (@(posedge clk) disable iff (!rstnInt)
        (clkEn && accessNow && !colCmd && !modeQ[`SGBM_BT_BIT] && blCode == `SGBM_BL8
         && stateQ == SGBM_RD)
        |-> accCol[2:0] == 3'(accColQ[2:0] + 3'h1) && accCol[7:3] == accColQ[7:3])
        else $error("sequential burst of eight did not step by one");
    AST_FULL_PAGE_STEP: assert property (@(posedge clk) disable iff (!rstnInt)
        (clkEn && accessNow && !colCmd && !modeQ[`SGBM_BT_BIT] && blCode == `SGBM_BLFP
         && stateQ == SGBM_RD)
        |-> accCol == 8'(accColQ + 8'h01))
        else $error("full page burst did not step by one");
    AST_INTER_DOWN: assert property (@(posedge clk) disable iff (!rstnInt)
        (clkEn && accessNow && !colCmd && modeQ[`SGBM_BT_BIT] && blCode == `SGBM_BL8
         && startColQ[2:0] == 3'h7 && stateQ == SGBM_RD)
        |-> accCol[2:0] == 3'(accColQ[2:0] - 3'h1))
        else $error("interleaved burst from 111 did not count down");
    AST_CL3_LATENCY: assert property (@(posedge clk) disable iff (!rstnInt)
        (clkEn && rdAcc && cl3) ##1 clkEn ##1 clkEn |=> dqOeQ)
        else $error("read data not driven three clocks after access");
    AST_STOP_ENDS: assert property (@(posedge clk) disable iff (!rstnInt)
        (clkEn && busy && stopNow && !colCmd) |-> !rdAcc && !normWrAcc ##1 stateQ == SGBM_IDLE)
        else $error("stopped burst kept accessing columns");
    AST_SINGLE_WRITE: assert property (@(posedge clk) disable iff (!rstnInt)
        (clkEn && normWrCmd && modeQ[`SGBM_SWB_BIT]) |=> stateQ == SGBM_IDLE)
        else $error("write burst longer than one with single write option");
    AST_BLOCK_ALL_COLS: assert property (@(posedge clk) disable iff (!rstnInt)
        (clkEn && blockCmd) |-> colHit == `SGBM_BLK_ALL ##1 stateQ == SGBM_IDLE)
        else $error("block write did not cover eight columns in one access");
    AST_PLANE_ARM: assert property (@(posedge clk) disable iff (!rstnInt)
        (clkEn && cmdAct) |=> wpbEnQ[$past(bankSel)] == $past(specialFunctionInput))
        else $error("activate did not set plane mask enable");
    AST_COLOUR_LOAD: assert property (@(posedge clk) disable iff (!rstnInt)
        (clkEn && cmdMode && specialFunctionInput && addr[`SGBM_SM_COLOUR_BIT])
        |=> colourQ == $past(dqIn))
        else $error("colour register did not capture data pins");
    AST_BYTE_KEEP: assert property (@(posedge clk) disable iff (!rstnInt)
        (clkEn && normWrAcc && dqm[0]) |=> memQ[$past(colIdx[0])][7:0] == $past(colNew[0][7:0])
        && $past(colNew[0][7:0]) == $past(memQ[colIdx[0]][7:0]))
        else $error("masked byte lane was changed");
    AST_CL2_LATENCY: assert property (@(posedge clk) disable iff (!rstnInt)
        (clkEn && rdAcc && !cl3) ##1 clkEn |=> dqOeQ)
        else $error("read data not driven two clocks after access");
    AST_NEW_COL_WINS: assert property (@(posedge clk) disable iff (!rstnInt)
        (clkEn && busy && colCmd) |-> accCol == addr[7:0] && (rdAcc || normWrAcc || blkAcc))
        else $error("column command did not start a new access at once");
    AST_BLOCK_PIXEL: assert property (@(posedge clk) disable iff (!rstnInt)
        (clkEn && blkAcc && !dqm[0] && !dqIn[0])
        |=> memQ[$past(colIdx[0])][7:0] == $past(memQ[colIdx[0]][7:0]))
        else $error("pixel with low enable was written in block write");
    AST_RESV_ONE: assert property (@(posedge clk) disable iff (!rstnInt)
        (clkEn && cmdRead && resvLen) |=> stateQ == SGBM_IDLE)
        else $error("reserved burst length did not act as length one");
endmodule

// *** sgbm_ctrl_model.sv ***
// controller model driving the command, address and data pins
`timescale 1ns/10ps
`include "sgbm_defines.svh"
module sgbm_ctrl_model (
    input wire logic clk,
    output logic chipSelN,
    output logic rowStrobeN,
    output logic colStrobeN,
    output logic writeEnN,
    output logic bankSel,
    output logic [10:0] addr,
    output logic specialFunctionInput,
    output logic [31:0] dqIn,
    output logic [3:0] dqm
);
    logic [2:0] lenCode;
    initial begin
        lenCode = `SGBM_BL1;
        chipSelN = 1'b1;
        {rowStrobeN, colStrobeN, writeEnN} = 3'h7;
        bankSel = 1'b0;
        addr = 11'h000;
        specialFunctionInput = 1'b0;
        dqIn = 32'h5A5A_5A5A;
        dqm = 4'hF;
    end
    // one command a call, never with auto precharge
    task automatic issue(input logic [2:0] c, input logic b, input logic [10:0] a,
        input logic s, input logic [31:0] d, input logic [3:0] m);
        chipSelN <= 1'b0;
        {rowStrobeN, colStrobeN, writeEnN} <= c;
        bankSel <= b;
        addr <= a;
        specialFunctionInput <= s;
        dqIn <= d;
        dqm <= m;
        @(posedge clk);
    endtask
    // released data lines do not keep their last value
    task automatic nop(input int n);
        repeat (n) begin
            chipSelN <= 1'b1;
            dqIn <= ~dqIn;
            dqm <= 4'hF;
            @(posedge clk);
        end
    endtask
    // one beat of a running write burst, no new command
    task automatic beat(input logic [31:0] d, input logic [3:0] m);
        chipSelN <= 1'b1;
        dqIn <= d;
        dqm <= m;
        @(posedge clk);
    endtask
    task automatic prog(input logic [10:0] v, input logic s, input logic [31:0] d);
        issue(`SGBM_CMD_PRE, 1'b0, 11'h400, 1'b0, d, 4'hF);
        issue(`SGBM_CMD_MODE, 1'b0, v, s, d, 4'h0);
        if (!s) lenCode = v[2:0];
    endtask
    task automatic stop();
        if (lenCode == `SGBM_BLFP) begin
            issue(`SGBM_CMD_STOP, 1'b0, 11'h000, 1'b0, dqIn, 4'hF);
        end else begin
            nop(1);
        end
    endtask
endmodule

// *** sgram_burst_and_mask_control_test.sv ***
// self-checking bench for the sgram burst and mask block
`timescale 1ns/10ps
`include "sgbm_defines.svh"
module sgram_burst_and_mask_control_test;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic clkEn = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata, dqIn, dqOut;
    logic avs_waitrequest, chipSelN, rowStrobeN, colStrobeN, writeEnN, bankSel, sfi, dqOe;
    logic [10:0] addr;
    logic [3:0] dqm;
    logic [31:0] mem [2][256];
    logic planeEn [2];
    logic [31:0] planeMask, colourVal;
    logic [2:0] curBl;
    logic curIl;
    logic [31:0] dqQ[$], avQ[$];
    integer seed = 32'h246fa898;
    int numErrors = 0;
    int checkCount = 0;
    int cycles = 0;
    always #12.5 clk = ~clk;
    sgbm_ctrl_model ctl (.clk(clk), .chipSelN(chipSelN), .rowStrobeN(rowStrobeN),
        .colStrobeN(colStrobeN), .writeEnN(writeEnN), .bankSel(bankSel), .addr(addr),
        .specialFunctionInput(sfi), .dqIn(dqIn), .dqm(dqm));
    sgbm_top dut (.clk(clk), .rstn(rstn), .clkEn(clkEn), .chipSelN(chipSelN),
        .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN), .writeEnN(writeEnN),
        .bankSel(bankSel), .addr(addr), .specialFunctionInput(sfi), .dqIn(dqIn), .dqm(dqm),
        .dqOut(dqOut), .dqOe(dqOe), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", checkCount, numErrors);
        if (numErrors == 0 && checkCount > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            numErrors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (dqOe === 1'b1 && dqQ.size() > 0) check("dqOut", dqOut, dqQ.pop_front());
        else if (dqOe === 1'b1) check("extra read word", 32'h1, 32'h0);
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && avQ.size() > 0) begin
            check("avs_readdata", avs_readdata, avQ.pop_front());
        end
        if (cycles == 6000) begin
            numErrors++;
            tallyAndFinish();
        end
    end
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        if (!wr) avQ.push_back(d);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic [7:0] col(input logic [7:0] s, input int i);
        logic [7:0] m;
        m = (curBl == `SGBM_BLFP) ? 8'hFF : (8'h01 << curBl) - 8'h01;
        if (curIl && (curBl == `SGBM_BL4 || curBl == `SGBM_BL8)) begin
            return (s & ~m) | ((s ^ i[7:0]) & m);
        end
        return (s & ~m) | ((s + i[7:0]) & m);
    endfunction
    task automatic prog(input logic [2:0] bl, input logic il, input logic [2:0] cl, input logic sw);
        curBl = bl;
        curIl = il;
        ctl.prog({1'b0, sw, 2'b00, cl, il, bl}, 1'b0, 32'h0000_0000);
        ctl.issue(`SGBM_CMD_ACT, 1'b0, 11'h000, planeEn[0], 32'h0000_0000, 4'h0);
        ctl.issue(`SGBM_CMD_ACT, 1'b1, 11'h000, planeEn[1], 32'h0000_0000, 4'h0);
    endtask
    task automatic wr(input logic b, input logic [7:0] c, input logic [31:0] d,
        input logic [3:0] m);
        logic [31:0] pm;
        logic [31:0] nv;
        pm = planeEn[b] ? planeMask : `SGBM_ONES32;
        nv = (mem[b][c] & ~pm) | (d & pm);
        for (int k = 0; k < 4; k++) if (m[k]) nv[8*k +: 8] = mem[b][c][8*k +: 8];
        mem[b][c] = nv;
        ctl.issue(`SGBM_CMD_WRITE, b, {3'b000, c}, 1'b0, d, m);
    endtask
    // write burst: two beats, one masked beat, then a same bank precharge
    task automatic wburst(input logic b, input logic [7:0] c, input logic [31:0] d);
        logic [31:0] pm;
        logic [7:0] c1;
        pm = planeEn[b] ? planeMask : `SGBM_ONES32;
        c1 = col(c, 1);
        wr(b, c, d, 4'h0);
        mem[b][c1] = (mem[b][c1] & ~pm) | (~d & pm);
        ctl.beat(~d, 4'h0);
        ctl.beat(d, 4'hF);
        ctl.issue(`SGBM_CMD_PRE, b, 11'h000, 1'b0, ~d, 4'h0);
    endtask
    task automatic blk(input logic b, input logic [7:0] c, input logic [31:0] p,
        input logic [3:0] m);
        logic [31:0] pm;
        logic [7:0] cc;
        pm = planeEn[b] ? planeMask : `SGBM_ONES32;
        for (int k = 0; k < 8; k++) begin
            cc = {c[7:3], k[2:0]};
            for (int y = 0; y < 4; y++) begin
                if (!m[y] && p[8*y+k]) begin
                    mem[b][cc][8*y +: 8] = (mem[b][cc][8*y +: 8] & ~pm[8*y +: 8])
                        | (colourVal[8*y +: 8] & pm[8*y +: 8]);
                end
            end
        end
        ctl.issue(`SGBM_CMD_WRITE, b, {3'b000, c}, 1'b1, p, m);
        ctl.nop(2);
    endtask
    task automatic rd(input logic b, input logic [7:0] s, input int beats, input int gap);
        for (int i = 0; i < beats; i++) dqQ.push_back(mem[b][col(s, i)]);
        ctl.issue(`SGBM_CMD_READ, b, {3'b000, s}, 1'b0, 32'h0000_0000, 4'h0);
        ctl.nop(gap);
    endtask
    task automatic drain(input string name);
        ctl.nop(6);
        check("read words left", 32'(dqQ.size()), 32'h0000_0000);
        $display("test %s done", name);
    endtask
    initial begin
        planeEn[0] = 1'b0;
        planeEn[1] = 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, `SGBM_OFF_MODE, {21'h00_0000, `SGBM_MODE_RST});
        bus(1'b0, `SGBM_OFF_PMASK, `SGBM_ONES32);
        bus(1'b0, `SGBM_OFF_COLOUR, `SGBM_ZERO32);
        bus(1'b0, 4'h2, `SGBM_ZERO32);
        bus(1'b1, `SGBM_OFF_MODE, 32'h0000_0233);
        bus(1'b0, `SGBM_OFF_MODE, 32'h0000_0233);
        avs_byteenable <= 4'h1;
        bus(1'b1, `SGBM_OFF_MODE, 32'h0000_0500);
        avs_byteenable <= 4'hF;
        bus(1'b0, `SGBM_OFF_MODE, 32'h0000_0200);
        $display("test registers done");
        prog(`SGBM_BL1, 1'b0, 3'h2, 1'b0);
        for (int i = 0; i < 512; i++) wr(i[8], i[7:0], $random(seed), 4'h0);
        for (int il = 0; il < 2; il++) begin
            for (int bl = 0; bl < 4; bl++) begin
                prog(bl[2:0], il[0], il[0] ? `SGBM_CL3 : 3'h2, 1'b0);
                rd(1'b0, 8'h00, 1 << bl, 1 << bl);
                rd(1'b0, 8'h07, 1 << bl, 1 << bl);
                rd(1'b1, 8'($random(seed)), 1 << bl, 1 << bl);
            end
        end
        drain("burst order");
        for (int t = 0; t < 2; t++) begin
            prog(`SGBM_BLFP, 1'b0, t[0] ? `SGBM_CL3 : 3'h2, 1'b0);
            rd(1'b0, 8'hFA, 10, 9);
            if (t[0]) ctl.issue(`SGBM_CMD_PRE, 1'b0, 11'h000, 1'b0, dqIn, 4'hF);
            else ctl.stop();
        end
        drain("full page end");
        prog(`SGBM_BL8, 1'b0, 3'h2, 1'b0);
        rd(1'b0, 8'h00, 2, 1);
        rd(1'b1, 8'h10, 8, 8);
        drain("interrupt");
        planeMask = $random(seed);
        colourVal = $random(seed);
        planeEn[1] = 1'b1;
        ctl.prog(11'h020, 1'b1, planeMask);
        ctl.prog(11'h040, 1'b1, colourVal);
        prog(`SGBM_BL4, 1'b0, 3'h2, 1'b1);
        for (int i = 0; i < 8; i++) wr(i[0], 8'h20 + 8'(4 * i), $random(seed), 4'($random(seed)));
        blk(1'b0, 8'h45, $random(seed) & 32'hFFFF_FFFE, 4'h0);
        blk(1'b1, 8'h6B, $random(seed), 4'($random(seed)));
        // a write presented while the clock enable is low must be lost
        clkEn <= 1'b0;
        ctl.issue(`SGBM_CMD_WRITE, 1'b0, 11'h090, 1'b0, ~mem[0][8'h90], 4'h0);
        ctl.nop(1);
        clkEn <= 1'b1;
        bus(1'b0, `SGBM_OFF_PMASK, planeMask);
        bus(1'b0, `SGBM_OFF_COLOUR, colourVal);
        for (int i = 0; i < 8; i++) rd(i[0], 8'h20 + 8'(4 * i), 4, 4);
        rd(1'b0, 8'h90, 4, 4);
        prog(`SGBM_BL8, 1'b0, 3'h2, 1'b0);
        rd(1'b0, 8'h40, 8, 8);
        rd(1'b1, 8'h68, 8, 8);
        prog(`SGBM_BL4, 1'b0, 3'h2, 1'b0);
        wburst(1'b1, 8'h8E, $random(seed));
        rd(1'b1, 8'h8C, 4, 4);
        drain("masking");
        prog(3'h5, 1'b0, 3'h2, 1'b0);
        rd(1'b0, 8'h43, 1, 2);
        bus(1'b0, `SGBM_OFF_STATUS, 32'h0005_4300);
        drain("reserved length");
        tallyAndFinish();
    end
endmodule
